/* logic/hbr_host_port.sv */
`timescale 1ns/1ns
module hbr_host_port
  import hbr_pkg::*;
#(
  parameter int DATA_W = 10
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  // host pins, all taken as synchronous
  input wire logic chip_sel_low_n,
  input wire logic chip_sel_high,
  input wire logic fetch_n,
  input wire logic store_n,
  input wire logic reg_sel,
  input wire logic [CTRL_W-1:0] data_in,
  // fifo side
  input wire logic [DATA_W-1:0] fifo_word,
  input wire logic [CNT_W-1:0] fifo_count,
  // converter status
  input wire logic [1:0] chan_count,
  input wire logic cont_mode,
  input wire logic conversion_clock_in,
  // outputs, all from flops
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic fifo_pop,
  output logic [CTRL_W-1:0] ctrl0,
  output logic [CTRL_W-1:0] ctrl1,
  output logic fifo_ready_flag
);

  // internal strobes from the pin gate
  hbr_strobe_if sb ();

  // control registers, indexed by reg_sel
  logic [CTRL_W-1:0] ctrl_reg [0:1];

  // sampled conversion clock, two stages for edges
  logic cclk_q;
  logic cclk_q2;

  // flag sequencer
  hbr_state_t state;
  hbr_state_t next_state;

  // reads still owed since the trigger was met
  logic [CNT_W-1:0] reads_left;
  logic [CNT_W-1:0] next_reads_left;

  // ---------------------------------------------------
  // decode of control fields
  // ---------------------------------------------------

  // direction select mode
  wire dir_mode = ctrl_reg[REG1_IDX][DIR_BIT];

  // pulse type when set, level when clear
  wire pulse_type = ctrl_reg[REG1_IDX][TYPE_BIT];

  // active high when set, active low when clear
  wire pol_high = ctrl_reg[REG1_IDX][POL_BIT];

  // two bit threshold code
  wire [1:0] thr_code = {ctrl_reg[REG1_IDX][CODE_HI_BIT],
                         ctrl_reg[REG1_IDX][CODE_LO_BIT]};

  // threshold picked by channel count and code
  wire [CNT_W-1:0] thr = THR_TAB[chan_count][thr_code];

  // trigger: fifo holds at least the threshold
  wire trig_met = (fifo_count >= thr);

  // conversion clock edges, seen one sample late
  wire cclk_rise = cclk_q & ~cclk_q2;
  wire cclk_fall = ~cclk_q & cclk_q2;

  // a completed read while reads are still owed
  wire read_done = sb.rd_fall & (reads_left != CNT_ZERO);

  // all owed reads finished
  wire reads_clear = (reads_left == CNT_ZERO);

  // flag active in these two states
  wire next_active = (next_state == S_LEVEL) |
                     (next_state == S_PULSE);

  // polarity applied before the output flop
  wire next_flag = pol_high ? next_active : ~next_active;

  // ---------------------------------------------------
  // strobe generation
  // ---------------------------------------------------

  // pin gate: selects, fetch and store into strobes
  hbr_strobe_gate u_gate (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clk_en(clk_en),
    .chip_sel_low_n(chip_sel_low_n),
    .chip_sel_high(chip_sel_high),
    .fetch_n(fetch_n),
    .store_n(store_n),
    .dir_mode(dir_mode),
    .sb(sb.gen)
  );

  // ---------------------------------------------------
  // control register writes
  // ---------------------------------------------------

  // written every cycle of the store strobe, so the
  // value held is the bus word just before it ends;
  // this honours data setup to the first invalid edge
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_reg[REG0_IDX] <= CTRL0_RST;
      ctrl_reg[REG1_IDX] <= CTRL1_RST;
    end else if (clk_en && sb.wr_int) begin
      // only these two registers are host writable
      ctrl_reg[reg_sel] <= data_in;
    end
  end

  // register contents straight out
  assign ctrl0 = ctrl_reg[REG0_IDX];
  assign ctrl1 = ctrl_reg[REG1_IDX];

  // ---------------------------------------------------
  // read path
  // ---------------------------------------------------

  // head word caught at strobe start, then popped;
  // drivers on for the whole strobe, one cycle late
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      data_out <= '0;
      data_oe <= 1'b0;
      fifo_pop <= 1'b0;
    end else if (clk_en) begin
      // enable follows the strobe
      data_oe <= sb.rd_int;
      // one pop per strobe
      fifo_pop <= sb.rd_rise;
      if (sb.rd_rise) begin
        // capture before the pop moves the head
        data_out <= fifo_word;
      end
    end
  end

  // ---------------------------------------------------
  // conversion clock sampling
  // ---------------------------------------------------

  // input already synchronous; second stage gives edges
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cclk_q <= 1'b0;
      cclk_q2 <= 1'b0;
    end else if (clk_en) begin
      cclk_q <= conversion_clock_in;
      cclk_q2 <= cclk_q;
    end
  end

  // ---------------------------------------------------
  // ready flag sequencer
  // ---------------------------------------------------

  // next state; a pulse waits for a rising edge of the
  // conversion clock and ends at the falling one, so it
  // is exactly half a period wide; in single mode the
  // clock may stand still, so the pulse is one cycle
  always_comb begin
    next_state = state;
    case (state)
      // trigger is checked only here
      S_CHECK: begin
        if (trig_met) begin
          if (!pulse_type) begin
            next_state = S_LEVEL;
          end else if (cont_mode) begin
            next_state = S_PEND;
          end else begin
            next_state = S_PULSE;
          end
        end
      end
      // level held until the first read starts
      S_LEVEL: begin
        if (sb.rd_rise) begin
          next_state = S_WAIT;
        end
      end
      // align pulse start to a clock rise
      S_PEND: begin
        if (cclk_rise) begin
          next_state = S_PULSE;
        end
      end
      // pulse ends at the clock fall, or after one cycle in single mode
      S_PULSE: begin
        if (!cont_mode || cclk_fall) begin
          next_state = S_WAIT;
        end
      end
      // hold off until the owed reads are done
      S_WAIT: begin
        if (reads_clear) begin
          next_state = S_CHECK;
        end
      end
      // illegal code: back to checking
      default: begin
        next_state = S_CHECK;
      end
    endcase
  end

  // owed read count: loaded at trigger, counted down
  // by completed reads in every other state
  always_comb begin
    next_reads_left = reads_left;
    if (state == S_CHECK) begin
      if (trig_met) begin
        next_reads_left = thr;
      end
    end else if (read_done) begin
      next_reads_left = reads_left - CNT_ONE;
    end
  end

  // sequencer flops; flag leaves reset inactive
  // for the reset polarity, active high
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state <= S_CHECK;
      reads_left <= CNT_ZERO;
      fifo_ready_flag <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      reads_left <= next_reads_left;
      fifo_ready_flag <= next_flag;
    end
  end

  // note: changing the type or code bits while a
  // flag is outstanding takes effect at the next check
endmodule // hbr_host_port

/* inc/hbr_pkg.sv */
package hbr_pkg;
  // control word width and fifo fill count width
  localparam int CTRL_W = 10;
  localparam int CNT_W = 5;
  // field positions in control register one
  localparam int CODE_LO_BIT = 2;
  localparam int CODE_HI_BIT = 3;
  localparam int TYPE_BIT = 4;
  localparam int POL_BIT = 5;
  localparam int DIR_BIT = 6;
  // register indexes
  localparam int REG0_IDX = 0;
  localparam int REG1_IDX = 1;
  // reset values: flag starts as active high pulse
  localparam logic [CTRL_W-1:0] CTRL0_RST = 10'h000;
  localparam logic [CTRL_W-1:0] CTRL1_RST = 10'h030;
  // step for the read counter
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  // thresholds by [channels-1][code]; reserved 4ch code reuses 12
  localparam logic [CNT_W-1:0] THR_TAB [0:3][0:3] = '{
    '{5'h01, 5'h04, 5'h08, 5'h0e},
    '{5'h02, 5'h04, 5'h08, 5'h0c},
    '{5'h03, 5'h06, 5'h09, 5'h0c},
    '{5'h04, 5'h08, 5'h0c, 5'h0c}
  };
  // ready flag sequencer states
  typedef enum logic [4:0] {
    S_CHECK = 5'h01,
    S_LEVEL = 5'h02,
    S_PEND = 5'h04,
    S_PULSE = 5'h08,
    S_WAIT = 5'h10
  } hbr_state_t;
endpackage

/* inc/hbr_strobe_if.sv */
`timescale 1ns/1ns
// internal strobes from the pin gate to the port logic
interface hbr_strobe_if;
  logic rd_int; // internal fetch strobe, high active
  logic wr_int; // internal store strobe, high active
  logic rd_rise; // one cycle at strobe start
  logic rd_fall; // one cycle at strobe end
  modport gen (output rd_int, output wr_int, output rd_rise, output rd_fall);
  modport use_side (input rd_int, input wr_int, input rd_rise, input rd_fall);
endinterface

/* logic/hbr_strobe_gate.sv */
`timescale 1ns/1ns
module hbr_strobe_gate
  import hbr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic chip_sel_low_n,
  input wire logic chip_sel_high,
  input wire logic fetch_n,
  input wire logic store_n,
  input wire logic dir_mode,
  hbr_strobe_if.gen sb
);
  // both selects valid
  wire qual = ~chip_sel_low_n & chip_sel_high;
  // read request: direction pin high, or fetch pin low
  wire rd_pin = dir_mode ? store_n : ~fetch_n;
  // write request: store pin low in both modes
  wire wr_pin = ~store_n;
  // fetch pin ignored in direction mode
  wire fetch_idle = dir_mode | fetch_n;
  // start needs the other strobe idle
  wire rd_go = qual & rd_pin & ~wr_pin;
  wire wr_go = qual & wr_pin & fetch_idle;
  // once on, a strobe ends at the first input to drop
  wire next_rd = sb.rd_int ? (qual & rd_pin) : rd_go;
  wire next_wr = sb.wr_int ? (qual & wr_pin) : wr_go;

  // strobe flops and edge pulses
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sb.rd_int <= 1'b0;
      sb.wr_int <= 1'b0;
      sb.rd_rise <= 1'b0;
      sb.rd_fall <= 1'b0;
    end else if (clk_en) begin
      sb.rd_int <= next_rd;
      sb.wr_int <= next_wr;
      sb.rd_rise <= next_rd & ~sb.rd_int;
      sb.rd_fall <= ~next_rd & sb.rd_int;
    end
  end
endmodule // hbr_strobe_gate

/* verification/hbr_host_port_checker.sv */
`timescale 1ns/1ns
module hbr_host_port_checker
  import hbr_pkg::*;
#(
  parameter int DATA_W = 10
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic chip_sel_low_n,
  input wire logic chip_sel_high,
  input wire logic fetch_n,
  input wire logic store_n,
  input wire logic reg_sel,
  input wire logic [CTRL_W-1:0] data_in,
  input wire logic [DATA_W-1:0] fifo_word,
  input wire logic cont_mode,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic fifo_pop,
  input wire logic [CTRL_W-1:0] ctrl0,
  input wire logic [CTRL_W-1:0] ctrl1,
  input wire logic fifo_ready_flag
);
  // both selects valid
  wire sel_ok = !chip_sel_low_n && chip_sel_high;
  // read pin differs by mode; fetch ignored in direction mode
  wire rd_req = sel_ok && store_n && (ctrl1[DIR_BIT] || !fetch_n);
  wire wr_req = sel_ok && !store_n && (ctrl1[DIR_BIT] || fetch_n);
  // flag active whatever the polarity
  wire flag_act = (fifo_ready_flag == ctrl1[POL_BIT]);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // read opens with the write side idle
  sequence s_rd_open;
    $rose(rd_req) && !$past(wr_req);
  endsequence
  // three clean write samples to one register
  sequence s_wr_held(s);
    (wr_req && !data_oe && reg_sel == s)[*3];
  endsequence
  AST_RD_START: assert property (s_rd_open |-> ##2 (fifo_pop && data_oe))
    else $error("read gave no pop or drive");
  AST_RD_DATA: assert property (fifo_pop |-> data_out == $past(fifo_word, 2))
    else $error("read word wrong");
  AST_POP_ONCE: assert property (fifo_pop |=> !fifo_pop)
    else $error("pop longer than one cycle");
  AST_OE_DROP: assert property ($fell(rd_req) |-> ##[1:3] !data_oe)
    else $error("drivers left on");
  AST_WR_REG0: assert property (s_wr_held(1'b0) |=> ctrl0 == $past(data_in))
    else $error("register zero not loaded");
  AST_WR_REG1: assert property (s_wr_held(1'b1) |=> ctrl1 == $past(data_in))
    else $error("register one not loaded");
  AST_WR_IDLE: assert property ((!wr_req)[*3] |=> $stable(ctrl0) && $stable(ctrl1))
    else $error("register changed without write");
  AST_LVL_DROP: assert property (!ctrl1[TYPE_BIT] && $rose(data_oe) && $past(flag_act)
    |-> !flag_act) else $error("level flag kept at read");
  AST_PULSE_LEN: assert property ($rose(flag_act) && ctrl1[TYPE_BIT] && cont_mode
    |-> flag_act[*4] ##1 !flag_act) else $error("pulse not half period");
endmodule // hbr_host_port_checker

bind hbr_host_port hbr_host_port_checker #(.DATA_W(DATA_W)) u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .chip_sel_low_n(chip_sel_low_n),
  .chip_sel_high(chip_sel_high), .fetch_n(fetch_n), .store_n(store_n),
  .reg_sel(reg_sel), .data_in(data_in), .fifo_word(fifo_word), .cont_mode(cont_mode),
  .data_out(data_out), .data_oe(data_oe), .fifo_pop(fifo_pop), .ctrl0(ctrl0),
  .ctrl1(ctrl1), .fifo_ready_flag(fifo_ready_flag));

/* verification/hbr_host_bfm.sv */
`timescale 1ns/1ns
module hbr_host_bfm
  import hbr_pkg::*;
(
  input wire logic clk_sys,
  output logic chip_sel_low_n,
  output logic chip_sel_high,
  output logic fetch_n,
  output logic store_n,
  output logic reg_sel,
  output logic [CTRL_W-1:0] data_in
);
  // bus idle from time zero
  initial begin
    chip_sel_low_n = 1'b1;
    chip_sel_high = 1'b0;
    fetch_n = 1'b1;
    store_n = 1'b1;
    reg_sel = 1'b0;
    data_in = '0;
  end
  // one access held n edges; fx pulls fetch low too
  task automatic acc(input logic wr, input logic dir, input logic fx, input logic sel,
      input logic [CTRL_W-1:0] d, input int n);
    @(posedge clk_sys);
    #1;
    reg_sel = sel;
    data_in = d;
    chip_sel_high = 1'b1;
    fetch_n = (wr | dir) & ~fx;
    store_n = ~wr;
    @(posedge clk_sys);
    #1;
    chip_sel_low_n = 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
    chip_sel_low_n = 1'b1;
    @(posedge clk_sys);
    #1;
    chip_sel_high = 1'b0;
    fetch_n = 1'b1;
    store_n = 1'b1;
    // released data has no pull, so show garbage
    data_in = ~d;
  endtask
endmodule // hbr_host_bfm

/* verification/adc_host_bus_and_ready_flag_tb_top.sv */
`timescale 1ns/1ns
module adc_host_bus_and_ready_flag_tb_top;
  import hbr_pkg::*;
  typedef struct packed {logic wr; logic dir; logic sel; logic [9:0] d;} hbr_row_t;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cont_mode = 1'b0;
  logic cclk = 1'b0;
  logic [9:0] fifo_word = 10'h3c3;
  logic [4:0] fifo_count = 5'h00;
  // active channels minus one, driven at one and four channels so those thresholds are reached
  logic [1:0] chan = 2'h0;
  wire chip_sel_low_n, chip_sel_high, fetch_n, store_n, reg_sel, data_oe, fifo_pop, flag;
  wire [9:0] data_in, ctrl0, ctrl1, data_out;
  logic [9:0] w;
  int fails = 0;
  int tests_run = 0;
  int pops = 0;
  int p, k;
  // one-channel thresholds per code
  int thr [4] = '{1, 4, 8, 14};
  // plain accesses: write, direction-mode, split-mode reads
  hbr_row_t rows [8] = '{'{1'b1, 1'b0, 1'b0, 10'h2a5}, '{1'b1, 1'b0, 1'b1, 10'h040},
    '{1'b1, 1'b1, 1'b0, 10'h15a}, '{1'b0, 1'b1, 1'b0, 10'h000},
    '{1'b0, 1'b1, 1'b0, 10'h000}, '{1'b1, 1'b1, 1'b1, 10'h000},
    '{1'b0, 1'b0, 1'b0, 10'h000}, '{1'b0, 1'b0, 1'b0, 10'h000}};
  always #5 clk_sys = ~clk_sys;
  // conversion clock, 8 system cycles, off the edge
  initial begin
    #36;
    forever #40 cclk = ~cclk;
  end
  // fifo model: each pop moves the head on
  always @(posedge clk_sys) begin
    if (fifo_pop === 1'b1) begin
      pops <= pops + 1;
      fifo_word <= fifo_word + 10'h001;
    end
  end
  hbr_host_bfm host (.clk_sys(clk_sys), .chip_sel_low_n(chip_sel_low_n),
    .chip_sel_high(chip_sel_high), .fetch_n(fetch_n), .store_n(store_n),
    .reg_sel(reg_sel), .data_in(data_in));
  hbr_host_port dut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1),
    .chip_sel_low_n(chip_sel_low_n), .chip_sel_high(chip_sel_high), .fetch_n(fetch_n),
    .store_n(store_n), .reg_sel(reg_sel), .data_in(data_in), .fifo_word(fifo_word),
    .fifo_count(fifo_count), .chan_count(chan), .cont_mode(cont_mode),
    .conversion_clock_in(cclk), .data_out(data_out), .data_oe(data_oe),
    .fifo_pop(fifo_pop), .ctrl0(ctrl0), .ctrl1(ctrl1), .fifo_ready_flag(flag));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic rd1;
    host.acc(1'b0, 1'b0, 1'b0, 1'b0, 10'h000, 3);
    cycles(3);
  endtask
  // cycles with an active-low flag asserted
  task automatic count_act(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      if (flag === 1'b0) c++;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    report_and_stop;
  end
  initial begin
    cycles(5);
    nrst = 1'b1;
    cycles(1);
    chk(ctrl0, 10'h000);
    chk(ctrl1, 10'h030);
    chk({9'h000, flag}, 10'h000);
    foreach (rows[i]) begin
      w = fifo_word;
      p = pops;
      host.acc(rows[i].wr, rows[i].dir, 1'b0, rows[i].sel, rows[i].d, 3);
      cycles(3);
      if (rows[i].wr) begin
        chk(rows[i].sel ? ctrl1 : ctrl0, rows[i].d);
      end else begin
        chk(data_out, w);
        chk(10'(pops - p), 10'h001);
      end
    end
    // both strobes at once: neither may act
    p = pops;
    host.acc(1'b1, 1'b0, 1'b1, 1'b0, 10'h0ff, 3);
    cycles(3);
    chk(ctrl0, 10'h15a);
    chk(10'(pops - p), 10'h000);
    // level flag, active high, every code
    for (int c = 0; c < 4; c++) begin
      host.acc(1'b1, 1'b0, 1'b0, 1'b1, 10'h020 | 10'(c << 2), 3);
      fifo_count = 5'(thr[c] - 1);
      cycles(3);
      chk({9'h000, flag}, 10'h000);
      fifo_count = 5'(thr[c]);
      cycles(3);
      chk({9'h000, flag}, 10'h001);
      for (int r = 1; r <= thr[c]; r++) begin
        rd1;
        chk({9'h000, flag}, {9'h000, r == thr[c]});
      end
      fifo_count = 5'h00;
      repeat (thr[c]) rd1;
    end
    // four channels, code one: threshold is eight
    chan = 2'h3;
    host.acc(1'b1, 1'b0, 1'b0, 1'b1, 10'h024, 3);
    fifo_count = 5'h07;
    cycles(3);
    chk({9'h000, flag}, 10'h000);
    fifo_count = 5'h08;
    cycles(3);
    chk({9'h000, flag}, 10'h001);
    fifo_count = 5'h00;
    repeat (8) rd1;
    chan = 2'h0;
    // pulse, active low, continuous conversion
    host.acc(1'b1, 1'b0, 1'b0, 1'b1, 10'h010, 3);
    cont_mode = 1'b1;
    fifo_count = 5'h01;
    count_act(40, k);
    chk(10'(k), 10'h004);
    host.acc(1'b0, 1'b0, 1'b0, 1'b0, 10'h000, 3);
    count_act(30, k);
    chk(10'(k), 10'h004);
    // reset in mid-run: registers and flag back to idle
    nrst = 1'b0;
    cycles(3);
    nrst = 1'b1;
    cycles(1);
    chk(ctrl0, 10'h000);
    chk(ctrl1, 10'h030);
    chk({9'h000, flag}, 10'h000);
    report_and_stop;
  end
endmodule // adc_host_bus_and_ready_flag_tb_top
